// >>> core/adc_parallel_control_port.sv
// Control and readout port of a 16-bit sampling converter
`include "adc_port_cfg.svh"
module adc_parallel_control_port (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        chip_select_n,
  input  wire logic        read_convert,
  input  wire logic        byte_swap,
  input  wire logic [15:0] sample_code,
  output logic             busy_n,
  output logic      [15:0] result_bits_out,
  output logic      [15:0] result_bits_oe,
  output logic             sample_hold,
  output logic             conv_start
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    adc_port_pkg::conv_state_t state;
    logic [12:0]               count;
    logic                      convert_req_d;
    logic [15:0]               held_sample;
    logic [15:0]               result;
    logic                      busy_n;
    logic [15:0]               out_bits;
    logic [15:0]               oe;
    logic                      hold;
    logic                      start;
  } port_state_t;

  port_state_t cur;
  port_state_t next_cur;
  logic        convert_req;
  logic [15:0] next_result;
  logic [15:0] steered;

  // Level-triggered combination of the two controls
  assign convert_req = ~chip_select_n & ~read_convert;

  // Result as it stands after this edge; kept apart from next_cur so the
  // steering path does not loop back into the state process
  assign next_result = (cur.state == adc_port_pkg::converting && cur.count == 13'h0000) ?
                       cur.held_sample : cur.result;

  result_steer u_steer (
    .word  (next_result),
    .swap  (byte_swap),
    .lines (steered)
  );

  // ****************************************
  // Next state
  // ****************************************
  // Start is taken on the rising edge of the combined request, but a
  // request still low when busy rises starts again (host must avoid it)
  always_comb begin
    next_cur               = cur;
    next_cur.convert_req_d = convert_req;
    next_cur.start         = 1'b0;
    unique case (cur.state)
      adc_port_pkg::idle: begin
        if (convert_req && (!cur.convert_req_d || cur.start == 1'b0 && cur.busy_n
            && cur.count == 13'h0001)) begin
          next_cur.state       = adc_port_pkg::converting;
          next_cur.count       = 13'(`CONV_CYCLES - 1);
          next_cur.busy_n      = 1'b0;
          next_cur.hold        = 1'b1;
          next_cur.start       = 1'b1;
          next_cur.held_sample = sample_code;
        end else begin
          next_cur.count = 13'h0000;
        end
      end
      adc_port_pkg::converting: begin
        // Requests are simply not looked at here
        if (cur.count == 13'h0000) begin
          next_cur.state  = adc_port_pkg::idle;
          next_cur.result = cur.held_sample;
          next_cur.busy_n = 1'b1;
          next_cur.hold   = 1'b0;
          next_cur.count  = 13'h0001;
        end else begin
          next_cur.count = cur.count - 13'h0001;
        end
      end
    endcase
    // Output drivers on only while selected with read/convert high
    next_cur.out_bits = steered;
    next_cur.oe = {16{~chip_select_n & read_convert}};
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      cur        <= '0;
      cur.state  <= adc_port_pkg::idle;
      cur.busy_n <= 1'b1;
      cur.result <= `RESULT_RESET;
    end else begin
      cur <= next_cur;
    end
  end

  assign busy_n          = cur.busy_n;
  assign result_bits_out = cur.out_bits;
  assign result_bits_oe  = cur.oe;
  assign sample_hold     = cur.hold;
  assign conv_start      = cur.start;

  // ****************************************
  // Assertions
  // ****************************************
  property p_hiz;
    @(posedge clk) disable iff (!reset_n)
      (chip_select_n || !read_convert) |=> result_bits_oe == 16'h0000;
  endproperty
  a_hiz: assert property (p_hiz) else $error("Result lines driven while deselected");

  property p_enable;
    @(posedge clk) disable iff (!reset_n)
      (!chip_select_n && read_convert) |=> result_bits_oe == 16'hFFFF;
  endproperty
  a_enable: assert property (p_enable) else $error("Result lines not enabled on read");

  property p_order;
    @(posedge clk) disable iff (!reset_n)
      (!byte_swap) |=> result_bits_out == cur.result;
  endproperty
  a_order: assert property (p_order) else $error("Result bit order wrong");

  property p_swap;
    @(posedge clk) disable iff (!reset_n)
      byte_swap |=> result_bits_out == {cur.result[7:0], cur.result[15:8]};
  endproperty
  a_swap: assert property (p_swap) else $error("Byte swap wrong");

  property p_start;
    @(posedge clk) disable iff (!reset_n)
      (busy_n && convert_req && !cur.convert_req_d) |=> !busy_n && conv_start;
  endproperty
  a_start: assert property (p_start) else $error("Conversion not started");

  property p_busy_len;
    @(posedge clk) disable iff (!reset_n)
      $fell(busy_n) |-> ##1 (!busy_n [*8]);
  endproperty
  a_busy_len: assert property (p_busy_len) else $error("Busy released early");

  property p_ignore;
    @(posedge clk) disable iff (!reset_n)
      (!busy_n && !$fell(busy_n)) |-> !conv_start;
  endproperty
  a_ignore: assert property (p_ignore) else $error("Start accepted while busy");

  property p_update;
    @(posedge clk) disable iff (!reset_n)
      $rose(busy_n) |-> cur.result == $past(cur.held_sample);
  endproperty
  a_update: assert property (p_update) else $error("Result not updated at busy rise");

  c_conv: cover property (@(posedge clk) disable iff (!reset_n) $rose(busy_n));
  c_read: cover property (@(posedge clk) disable iff (!reset_n)
    result_bits_oe[0] && !busy_n);
  c_swap: cover property (@(posedge clk) disable iff (!reset_n)
    result_bits_oe[0] && byte_swap);
  c_restart: cover property (@(posedge clk) disable iff (!reset_n)
    $rose(busy_n) ##1 $fell(busy_n));

  // Hold is on from the very cycle the start pulse shows
  property p_hold_start;
    @(posedge clk) disable iff (!reset_n)
      conv_start |-> sample_hold;
  endproperty
  a_hold_start: assert property (p_hold_start) else $error("Sample not held at start");

  property p_start_pulse;
    @(posedge clk) disable iff (!reset_n)
      conv_start |=> !conv_start;
  endproperty
  a_start_pulse: assert property (p_start_pulse) else $error("Start pulse too long");

  // Whole busy window counted from outside the down counter
  property p_busy_full;
    @(posedge clk) disable iff (!reset_n)
      $fell(busy_n) |-> ##200 $rose(busy_n);
  endproperty
  a_busy_full: assert property (p_busy_full) else $error("Busy window length wrong");

  property p_result_stable;
    @(posedge clk) disable iff (!reset_n)
      !$rose(busy_n) |-> $stable(cur.result);
  endproperty
  a_result_stable: assert property (p_result_stable) else $error("Result changed early");

  // A request still low as busy rises starts again at once and takes a fresh sample
  property p_restart;
    @(posedge clk) disable iff (!reset_n)
      ($rose(busy_n) && convert_req) |=> !busy_n && conv_start;
  endproperty
  a_restart: assert property (p_restart) else $error("Held request did not restart");

  property p_quiet;
    @(posedge clk) disable iff (!reset_n)
      (busy_n && !convert_req) |=> busy_n;
  endproperty
  a_quiet: assert property (p_quiet) else $error("Conversion started with no request");

endmodule

// >>> core/adc_port_cfg.svh
// Constants for the converter control and readout port
`ifndef ADC_PORT_CFG_SVH
`define ADC_PORT_CFG_SVH

`define CLK_PERIOD_NS      40
`define HOLD_LOW_MIN_NS    40
`define HOLD_LOW_CYCLES    ((`HOLD_LOW_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CONV_TIME_NS       8000
`define CONV_CYCLES        (`CONV_TIME_NS / `CLK_PERIOD_NS)
`define RESULT_WIDTH       16
`define RESULT_RESET       16'h0000
`define BYTE_WIDTH         8

`endif

// >>> core/adc_port_pkg.sv
// Types for the converter control and readout port
package adc_port_pkg;
  typedef enum logic [0:0] {
    idle,
    converting
  } conv_state_t;
endpackage

// >>> core/result_steer.sv
// Byte steering of the result word onto the result lines
`include "adc_port_cfg.svh"
module result_steer (
  input  wire logic [15:0] word,
  input  wire logic        swap,
  output logic      [15:0] lines
);
  // Upper byte on upper lines unless swap asked for
  always_comb begin
    if (swap) begin
      lines = {word[`BYTE_WIDTH-1:0], word[15:`BYTE_WIDTH]};
    end else begin
      lines = word;
    end
  end
endmodule

// >>> verif/host_ctrl_model.sv
// Host-side driver of the converter control lines
module host_ctrl_model (
  input  wire logic clk,
  input  wire logic busy_n,
  output logic      chip_select_n,
  output logic      read_convert
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    chip_select_n = 1'b1;
    read_convert  = 1'b1;
  end
  // Lines move just after an edge and hold for a full cycle
  task automatic drive(input logic cs, input logic rc);
    @(posedge clk);
    #1 chip_select_n = cs;
    read_convert = rc;
  endtask
  // Low pair held one cycle, released long before busy returns
  // Polls busy first: a real host never commands a running conversion
  task automatic convert(input logic by_cs);
    while (busy_n !== 1'b1) begin
      @(posedge clk);
    end
    drive(by_cs, ~by_cs);
    drive(1'b0, 1'b0);
    drive(1'b1, 1'b1);
  endtask
endmodule

// >>> verif/adc_parallel_control_port_bench.sv
// Bench for the converter control and readout port
`include "adc_port_cfg.svh"
module adc_parallel_control_port_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk, reset_n, cs_n, rc, bs, busy_n;
  logic        conv_start, sample_hold;
  logic [15:0] code, out, oe;
  int          n_mismatch = 0;
  int          n_checks = 0;
  int          cyc = 0;
  host_ctrl_model host (.clk(clk), .busy_n(busy_n), .chip_select_n(cs_n), .read_convert(rc));
  adc_parallel_control_port dut_u (.clk(clk), .reset_n(reset_n), .chip_select_n(cs_n),
    .read_convert(rc), .byte_swap(bs), .sample_code(code), .busy_n(busy_n),
    .result_bits_out(out), .result_bits_oe(oe), .sample_hold(sample_hold),
    .conv_start(conv_start));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // Hang guard, far above five conversions
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_mismatch++;
      finish_test();
    end
  end
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      n_mismatch++;
    end
  endtask
  // Bounded wait; the count pins the busy length, less the edges already
  // past the start edge when the wait begins
  task automatic wait_busy(input int spent);
    int n;
    for (n = 0; n < 250 && busy_n !== 1'b1; n++) begin
      @(posedge clk);
      #1;
    end
    chk("busy_len", 16'(`CONV_CYCLES - spent), n[15:0]);
  endtask
  task automatic rd(input logic [15:0] exp);
    host.drive(1'b0, 1'b1);
    @(posedge clk);
    #1 chk("oe", 16'hFFFF, oe);
    chk("result", exp, out);
  endtask
  task automatic t_basic;
    code = 16'hA53C;
    host.convert(1'b0);
    chk("busy_n", 16'h0000, {15'h0000, busy_n});
    chk("conv_start", 16'h0001, {15'h0000, conv_start});
    chk("sample_hold", 16'h0001, {15'h0000, sample_hold});
    wait_busy(0);
    chk("hold_end", 16'h0000, {15'h0000, sample_hold});
    rd(16'hA53C);
    $display("test basic done");
  endtask
  task automatic t_select_swap;
    code = 16'h8001;
    host.convert(1'b1);
    wait_busy(0);
    bs = 1'b1;
    rd(16'h0180);
    bs = 1'b0;
    rd(16'h8001);
    host.drive(1'b1, 1'b1);
    @(posedge clk);
    #1 chk("oe_idle", 16'h0000, oe);
    $display("test select swap done");
  endtask
  // A second command inside the busy window must leave no trace
  task automatic t_ignore;
    code = 16'h1234;
    host.convert(1'b0);
    code = 16'hFFFF;
    host.drive(1'b0, 1'b0);
    @(posedge clk);
    #1 chk("oe_conv", 16'h0000, oe);
    chk("start_ignored", 16'h0000, {15'h0000, conv_start});
    host.drive(1'b1, 1'b1);
    wait_busy(3);
    rd(16'h1234);
    repeat (3) @(posedge clk);
    #1 chk("no_restart", 16'h0001, {15'h0000, busy_n});
    $display("test ignore done");
  endtask
  // Host fault: pair still low as busy rises starts a fresh conversion
  task automatic t_late_release;
    code = 16'h5A5A;
    host.drive(1'b0, 1'b1);
    host.drive(1'b0, 1'b0);
    @(posedge clk);
    #1 wait_busy(0);
    @(posedge clk);
    #1 chk("restart", 16'h0001, {15'h0000, conv_start});
    chk("restart_busy", 16'h0000, {15'h0000, busy_n});
    host.drive(1'b1, 1'b1);
    wait_busy(1);
    rd(16'h5A5A);
    $display("test late release done");
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    reset_n = 1'b0;
    bs = 1'b0;
    code = 16'h0000;
    repeat (2) @(posedge clk);
    #1 reset_n = 1'b1;
    t_basic();
    t_select_swap();
    t_ignore();
    t_late_release();
    finish_test();
  end
endmodule
